// ### inc/adc_dm_pkg.sv
// Constants and types shared by the result modification stage
`default_nettype none
package adc_dm_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_GROUPS = 12;
  localparam int unsigned NUM_RES = 16;
  localparam int unsigned NUM_ENT = NUM_GROUPS * NUM_RES;
  localparam int unsigned RAW_W = 12;
  localparam int unsigned RES_W = 16;
  localparam int unsigned FILT_W = 14;
  localparam int unsigned GRP_W = 4;
  localparam int unsigned REG_W = 4;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------
  // Special result registers and the last group
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] REF_REG = 4'h0;
  localparam logic [REG_W-1:0] FILT_REG_LO = 4'h7;
  localparam logic [REG_W-1:0] FILT_REG_HI = 4'hF;
  localparam logic [GRP_W-1:0] LAST_GROUP = 4'hB;

  // ---------------------------------------------------------------
  // Mode select codes and filter codes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_REDUCE = 2'h0;
  localparam logic [1:0] MODE_FILTER = 2'h1;
  localparam logic [1:0] MODE_DIFF = 2'h2;
  localparam logic [3:0] RC_OFF = 4'h0;
  localparam logic [3:0] IIR_CODE_A = 4'hE;
  localparam logic [3:0] IIR_CODE_B = 4'hF;

  // ---------------------------------------------------------------
  // Register port address layout
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_REG_LSB = 0;
  localparam int unsigned ADDR_KIND_BIT = 4;
  localparam int unsigned ADDR_GRP_LSB = 5;
  localparam int unsigned ADDR_TOP_BIT = 9;
  localparam logic KIND_CTRL = 1'b0;
  localparam logic KIND_RESULT = 1'b1;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_RC_LSB = 0;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned RES_DATA_LSB = 0;
  localparam int unsigned RES_CNT_LSB = 16;
  localparam int unsigned RES_VF_BIT = 31;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [3:0] RC_RST = 4'h0;
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

endpackage : adc_dm_pkg
`default_nettype wire

// ### src/adc_result_modify.sv
// Result modification stage: reduction, filtering and difference per result register
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_result_modify
  import adc_dm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Conversion results from the converter core
  input wire logic conv_valid_i,
  input wire logic [adc_dm_pkg::GRP_W-1:0] conv_group_i,
  input wire logic [adc_dm_pkg::REG_W-1:0] conv_reg_i,
  input wire logic [adc_dm_pkg::RAW_W-1:0] conv_data_i,
  // Register port
  input wire logic [adc_dm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [adc_dm_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [adc_dm_pkg::DATA_W-1:0] rdata_o
);
  import adc_dm_pkg::*;

  // ---------------------------------------------------------------
  // Per-register state
  // ---------------------------------------------------------------
  logic [1:0] mode_q [NUM_ENT];
  logic [3:0] rc_q [NUM_ENT];
  logic [RES_W-1:0] res_q [NUM_ENT];
  logic [3:0] cnt_q [NUM_ENT];
  logic vf_q [NUM_ENT];
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  logic [GRP_W-1:0] bus_grp;
  logic [REG_W-1:0] bus_reg;
  logic [IDX_W-1:0] bus_idx;
  logic bus_kind;
  logic bus_mapped;
  logic ctrl_wr;
  logic res_rd;
  logic ctrl_rd;

  // Address split; groups above the last and the top bit are unmapped
  assign bus_grp = addr_i[ADDR_GRP_LSB +: GRP_W];
  assign bus_reg = addr_i[ADDR_REG_LSB +: REG_W];
  assign bus_kind = addr_i[ADDR_KIND_BIT];
  assign bus_idx = {bus_grp, bus_reg};
  assign bus_mapped = !addr_i[ADDR_TOP_BIT] && (bus_grp <= LAST_GROUP);
  assign ctrl_wr = wr_i && bus_mapped && (bus_kind == KIND_CTRL);
  assign res_rd = rd_i && bus_mapped && (bus_kind == KIND_RESULT);
  assign ctrl_rd = rd_i && bus_mapped && (bus_kind == KIND_CTRL);

  // ---------------------------------------------------------------
  // Conversion decode
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] cv_idx;
  logic [IDX_W-1:0] ref_idx;
  logic cv_hit;
  logic [1:0] cv_mode;
  logic [3:0] cv_rc;
  logic [3:0] cv_cnt;
  logic [RES_W-1:0] cv_res;
  logic filt_ok;
  logic diff_ok;
  logic use_reduce;
  logic use_filter;
  logic use_diff;

  // Target entry and its current settings
  assign cv_idx = {conv_group_i, conv_reg_i};
  assign ref_idx = {conv_group_i, REF_REG};
  assign cv_hit = conv_valid_i && (conv_group_i <= LAST_GROUP);
  assign cv_mode = mode_q[cv_idx];
  assign cv_rc = rc_q[cv_idx];
  assign cv_cnt = cnt_q[cv_idx];
  assign cv_res = res_q[cv_idx];
  assign filt_ok = (conv_reg_i == FILT_REG_LO) || (conv_reg_i == FILT_REG_HI);
  assign diff_ok = (conv_reg_i != REF_REG);
  assign use_reduce = (cv_mode == MODE_REDUCE);
  assign use_filter = (cv_mode == MODE_FILTER) && filt_ok;
  assign use_diff = (cv_mode == MODE_DIFF) && diff_ok;

  // ---------------------------------------------------------------
  // Filter units on registers 7 and 15 of each group
  // ---------------------------------------------------------------
  logic [FILT_W-1:0] filt_y [NUM_GROUPS][2];

  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    for (genvar k = 0; k < 2; k++) begin : g_filt
      localparam logic [IDX_W-1:0] FIDX = IDX_W'(g * NUM_RES) + (k == 0 ? IDX_W'(FILT_REG_LO) : IDX_W'(FILT_REG_HI));
      logic f_en;
      logic f_clr;

      // Step on a filtered sample, clear when this register is reconfigured
      assign f_en = cv_hit && use_filter && (cv_idx == FIDX);
      assign f_clr = ctrl_wr && (bus_idx == FIDX);

      result_filter u_filt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clr_i(f_clr),
        .en_i(f_en),
        .code_i(rc_q[FIDX]),
        .sample_i(conv_data_i),
        .y_o(filt_y[g][k])
      );
    end
  end

  // ---------------------------------------------------------------
  // Next value for the targeted result register
  // ---------------------------------------------------------------
  logic [RES_W-1:0] res_new;
  logic [3:0] cnt_new;
  logic vf_set;
  logic seq_start;
  logic [FILT_W-1:0] filt_sel;

  // A sequence starts whenever the counter is idle at zero
  assign seq_start = (cv_cnt == CNT_RST);
  assign filt_sel = filt_y[conv_group_i][conv_reg_i == FILT_REG_HI];

  // Mode dependent result, counter and valid-set
  always_comb begin
    res_new = {{(RES_W-RAW_W){1'b0}}, conv_data_i};
    cnt_new = CNT_RST;
    vf_set = 1'b1;
    if (use_reduce) begin
      if (seq_start) begin
        res_new = {{(RES_W-RAW_W){1'b0}}, conv_data_i};
        cnt_new = cv_rc;
        vf_set = (cv_rc == RC_OFF);
      end else begin
        res_new = cv_res + {{(RES_W-RAW_W){1'b0}}, conv_data_i};
        cnt_new = cv_cnt - 4'h1;
        vf_set = (cv_cnt == 4'h1);
      end
    end else if (use_filter) begin
      res_new = {{(RES_W-FILT_W){1'b0}}, filt_sel};
    end else if (use_diff) begin
      res_new = {{(RES_W-RAW_W){1'b0}}, conv_data_i} - res_q[ref_idx];
    end
  end

  // ---------------------------------------------------------------
  // Per-entry storage
  // ---------------------------------------------------------------
  for (genvar e = 0; e < NUM_ENT; e++) begin : g_ent
    logic e_cv;
    logic e_cfg;
    logic e_rd;

    assign e_cv = cv_hit && (cv_idx == IDX_W'(e));
    assign e_cfg = ctrl_wr && (bus_idx == IDX_W'(e));
    assign e_rd = res_rd && (bus_idx == IDX_W'(e));

    // Reconfiguration beats a result; a new valid beats the read clear
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        mode_q[e] <= MODE_RST;
        rc_q[e] <= RC_RST;
        res_q[e] <= RES_RST;
        cnt_q[e] <= CNT_RST;
        vf_q[e] <= 1'b0;
      end else if (e_cfg) begin
        mode_q[e] <= wdata_i[CTRL_MODE_LSB +: 2];
        rc_q[e] <= wdata_i[CTRL_RC_LSB +: 4];
        res_q[e] <= RES_RST;
        cnt_q[e] <= CNT_RST;
        vf_q[e] <= 1'b0;
      end else begin
        if (e_cv) begin
          res_q[e] <= res_new;
          cnt_q[e] <= cnt_new;
        end
        // Flag only drops on a read; a new sequence start leaves it alone
        vf_q[e] <= (e_cv && vf_set) || (vf_q[e] && !e_rd);
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Control reads return settings; result reads return flag, counter, data
  always_comb begin
    rdata_d = RDATA_RST;
    if (ctrl_rd) begin
      rdata_d[CTRL_MODE_LSB +: 2] = mode_q[bus_idx];
      rdata_d[CTRL_RC_LSB +: 4] = rc_q[bus_idx];
    end else if (res_rd) begin
      rdata_d[RES_VF_BIT] = vf_q[bus_idx];
      rdata_d[RES_CNT_LSB +: 4] = cnt_q[bus_idx];
      rdata_d[RES_DATA_LSB +: RES_W] = res_q[bus_idx];
    end
  end

  // Read data stand for the cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

endmodule // adc_result_modify
`default_nettype wire

// ### src/result_filter.sv
// Three-tap FIR / first-order IIR filter for one filter-capable result register
`timescale 1ns/1ps
`default_nettype none
module result_filter
  import adc_dm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [3:0] code_i,
  // Sample in, filtered value out
  input wire logic [adc_dm_pkg::RAW_W-1:0] sample_i,
  output logic [adc_dm_pkg::FILT_W-1:0] y_o
);
  import adc_dm_pkg::*;

  logic [RAW_W-1:0] x1_q;
  logic [RAW_W-1:0] x2_q;
  logic [FILT_W-1:0] y_q;
  logic [1:0] ca;
  logic [1:0] cb;
  logic [1:0] cc;
  logic is_iir;
  logic [FILT_W-1:0] fir_y;
  logic [FILT_W+1:0] iir_fb;
  logic [FILT_W-1:0] iir_y;

  // ---------------------------------------------------------------
  // Coefficient table
  // ---------------------------------------------------------------
  // Tap weights per code; FIR sums to 3 or 4, IIR weight of new sample
  always_comb begin
    case (code_i)
      4'h0: {ca, cb, cc} = {2'd2, 2'd1, 2'd0};
      4'h1: {ca, cb, cc} = {2'd1, 2'd2, 2'd0};
      4'h2: {ca, cb, cc} = {2'd2, 2'd0, 2'd1};
      4'h3: {ca, cb, cc} = {2'd1, 2'd1, 2'd1};
      4'h4: {ca, cb, cc} = {2'd1, 2'd0, 2'd2};
      4'h5: {ca, cb, cc} = {2'd3, 2'd1, 2'd0};
      4'h6: {ca, cb, cc} = {2'd2, 2'd2, 2'd0};
      4'h7: {ca, cb, cc} = {2'd1, 2'd3, 2'd0};
      4'h8: {ca, cb, cc} = {2'd3, 2'd0, 2'd1};
      4'h9: {ca, cb, cc} = {2'd2, 2'd1, 2'd1};
      4'hA: {ca, cb, cc} = {2'd1, 2'd2, 2'd1};
      4'hB: {ca, cb, cc} = {2'd2, 2'd0, 2'd2};
      4'hC: {ca, cb, cc} = {2'd1, 2'd1, 2'd2};
      4'hD: {ca, cb, cc} = {2'd1, 2'd0, 2'd3};
      4'hE: {ca, cb, cc} = {2'd2, 2'd2, 2'd0};
      default: {ca, cb, cc} = {2'd3, 2'd0, 2'd0};
    endcase
  end

  // ---------------------------------------------------------------
  // Filter arithmetic
  // ---------------------------------------------------------------
  // Unscaled outputs: gain 3 or 4 kept, result is 14 bits wide
  assign is_iir = (code_i == IIR_CODE_A) || (code_i == IIR_CODE_B);
  assign fir_y = FILT_W'(ca * sample_i) + FILT_W'(cb * x1_q) + FILT_W'(cc * x2_q);
  // IIR feedback keeps (4-a)/4 of the last output so the DC gain is 4
  assign iir_fb = (FILT_W+2)'((3'd4 - {1'b0, ca}) * y_q) >> 2;
  assign iir_y = FILT_W'(ca * sample_i) + iir_fb[FILT_W-1:0];
  assign y_o = is_iir ? iir_y : fir_y;

  // History registers, cleared on reset and on reconfiguration
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clr_i) begin
      x1_q <= '0;
      x2_q <= '0;
      y_q <= '0;
    end else if (en_i) begin
      x1_q <= sample_i;
      x2_q <= x1_q;
      y_q <= y_o;
    end
  end

endmodule // result_filter
`default_nettype wire

// ### verification/adc_result_modify_monitor.sv
// Port checker for the result modification stage
`timescale 1ns/1ps
`default_nettype none
module adc_result_modify_monitor
  import adc_dm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Conversion stream
  input wire logic conv_valid_i,
  input wire logic [adc_dm_pkg::GRP_W-1:0] conv_group_i,
  input wire logic [adc_dm_pkg::REG_W-1:0] conv_reg_i,
  // Register port
  input wire logic [adc_dm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [adc_dm_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [adc_dm_pkg::DATA_W-1:0] rdata_o
);
  import adc_dm_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Steps of write-then-read, read-then-read and conversion-then-read
  sequence s_ctrl_wr;
    wr_i && !addr_i[9] && addr_i[8:5] <= LAST_GROUP && addr_i[4] == KIND_CTRL;
  endsequence
  sequence s_rd_same;
    rd_i && addr_i == $past(addr_i);
  endsequence
  sequence s_conv;
    conv_valid_i && conv_group_i <= LAST_GROUP && !wr_i;
  endsequence
  sequence s_rd_conv;
    rd_i && addr_i == {1'b0, $past(conv_group_i), KIND_RESULT, $past(conv_reg_i)};
  endsequence
  sequence s_rd_res;
    rd_i && addr_i[4] == KIND_RESULT && !(conv_valid_i && conv_group_i == addr_i[8:5] && conv_reg_i == addr_i[3:0]);
  endsequence
  // Read data timing and field layout
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero without a read");
  unmapped_rd_a: assert property (rd_i && (addr_i[9] || addr_i[8:5] > LAST_GROUP) |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read returned data");
  ctrl_fields_a: assert property (rd_i && addr_i[4] == KIND_CTRL |=> rdata_o[31:6] == 26'h0)
    else $error("control read has stray bits");
  res_fields_a: assert property (rd_i && addr_i[4] == KIND_RESULT |=> rdata_o[30:20] == 11'h000)
    else $error("result read has stray bits");
  // Register behaviour over several cycles
  ctrl_readback_a: assert property (s_ctrl_wr ##1 s_rd_same |=> rdata_o == {26'h0, $past(wdata_i[5:0], 2)})
    else $error("control read back differs from write");
  cfg_clear_a: assert property (s_ctrl_wr ##1 (rd_i && addr_i == ($past(addr_i) | 10'h010)) |=> rdata_o == 32'h0)
    else $error("control write did not clear the result");
  rd_clear_a: assert property (s_rd_res ##1 s_rd_same |=> !rdata_o[31])
    else $error("flag still set after read");
  done_flag_a: assert property (s_conv ##1 s_rd_conv |=> rdata_o[19:16] != 4'h0 || rdata_o[31])
    else $error("counter zero without flag");
endmodule // adc_result_modify_monitor
bind adc_result_modify adc_result_modify_monitor mon_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .conv_valid_i(conv_valid_i), .conv_group_i(conv_group_i), .conv_reg_i(conv_reg_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
`default_nettype wire

// ### verification/conv_core_model.sv
// Behavioural converter core that hands raw results to the stage
`timescale 1ns/1ps
`default_nettype none
module conv_core_model
  import adc_dm_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Result stream
  output logic conv_valid_o,
  output logic [adc_dm_pkg::GRP_W-1:0] conv_group_o,
  output logic [adc_dm_pkg::REG_W-1:0] conv_reg_o,
  output logic [adc_dm_pkg::RAW_W-1:0] conv_data_o
);
  import adc_dm_pkg::*;
  // Idle lines at time zero
  initial begin
    conv_valid_o = 1'b0;
    conv_group_o = 4'h0;
    conv_reg_o = 4'h0;
    conv_data_o = 12'h000;
  end
  // Hands over n back-to-back results, then scrambles the released lines
  task automatic send(input int g, input int r, input logic [RAW_W-1:0] d, input int n = 1);
    conv_valid_o <= 1'b1;
    conv_group_o <= 4'(g);
    conv_reg_o <= 4'(r);
    conv_data_o <= d;
    repeat (n) @(posedge clk_i);
    conv_valid_o <= 1'b0;
    conv_group_o <= ~4'(g);
    conv_reg_o <= ~4'(r);
    conv_data_o <= ~d;
  endtask
endmodule // conv_core_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking testbench for the result modification stage
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_dm_pkg::*;
  logic clk_i, rst_n_i, wr_i, rd_i, conv_valid;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic [GRP_W-1:0] conv_group;
  logic [REG_W-1:0] conv_reg;
  logic [RAW_W-1:0] conv_data;
  int fails, checks, cycles;
  int fa[16] = '{2, 1, 2, 1, 1, 3, 2, 1, 3, 2, 1, 2, 1, 1, 2, 3};
  int fb[16] = '{1, 2, 0, 1, 0, 1, 2, 3, 0, 1, 2, 0, 1, 0, 0, 0};
  int fc[16] = '{0, 0, 1, 1, 2, 0, 0, 0, 1, 1, 1, 2, 2, 3, 0, 0};
  logic [RAW_W-1:0] xs[3] = '{12'h123, 12'hFFF, 12'h456};
  adc_result_modify dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .conv_valid_i(conv_valid), .conv_group_i(conv_group),
    .conv_reg_i(conv_reg), .conv_data_i(conv_data), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o));
  conv_core_model core_u (.clk_i(clk_i), .conv_valid_o(conv_valid), .conv_group_o(conv_group),
    .conv_reg_o(conv_reg), .conv_data_o(conv_data));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Address and result word builders
  function automatic logic [ADDR_W-1:0] ad(input int g, input int r, input logic k);
    return {1'b0, 4'(g), k, 4'(r)};
  endfunction
  function automatic logic [DATA_W-1:0] rv(input logic f, input int c, input int d);
    return {f, 11'h000, 4'(c), 16'(d)};
  endfunction
  // Compare, write and read helpers; write and read enter and leave just after a rising edge, compare runs at the falling edge
  task automatic check(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input bit gap = 1'b1);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (gap) @(posedge clk_i);
  endtask
  task automatic rd_chk(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input int reps = 1);
    rd_i <= 1'b1;
    addr_i <= a;
    repeat (reps) @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check(n, e, rdata_o);
    @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Scenarios
  task automatic t_reduce();
    rd_chk("rst_res", ad(11, 15, KIND_RESULT), 32'h0);
    bus_wr(ad(2, 5, KIND_CTRL), 32'h0000_0003);
    core_u.send(2, 5, 12'h100);
    rd_chk("red_start", ad(2, 5, KIND_RESULT), rv(1'b0, 3, 32'h100));
    core_u.send(2, 5, 12'h100, 3);
    rd_chk("red_sum", ad(2, 5, KIND_RESULT), rv(1'b1, 0, 32'h400));
    core_u.send(2, 5, 12'h200, 4);
    @(posedge clk_i);
    core_u.send(2, 5, 12'h050);
    rd_chk("red_unread", ad(2, 5, KIND_RESULT), rv(1'b1, 3, 32'h050));
    rd_chk("red_cleared", ad(2, 5, KIND_RESULT), rv(1'b0, 3, 32'h050));
    bus_wr(ad(11, 15, KIND_CTRL), 32'h0000_000F);
    core_u.send(11, 15, 12'hFFF, 16);
    rd_chk("red_16", ad(11, 15, KIND_RESULT), rv(1'b1, 0, 32'hFFF0));
    bus_wr(ad(0, 0, KIND_CTRL), 32'h0000_0000);
    core_u.send(0, 0, 12'hABC);
    rd_chk("red_off", ad(0, 0, KIND_RESULT), rv(1'b1, 0, 32'hABC));
    $display("done reduction");
  endtask
  task automatic t_filter();
    int y, x1, x2, r, c;
    for (int k = 0; k < 32; k++) begin
      r = (k < 16) ? 7 : 15;
      c = k % 16;
      bus_wr(ad(3, r, KIND_CTRL), {26'h0, MODE_FILTER, 4'(c)});
      y = 0;
      x1 = 0;
      x2 = 0;
      for (int i = 0; i < 3; i++) begin
        core_u.send(3, r, xs[i]);
        if (c >= 14) y = fa[c] * xs[i] + (((4 - fa[c]) * y) >> 2);
        else y = fa[c] * xs[i] + fb[c] * x1 + fc[c] * x2;
        x2 = x1;
        x1 = xs[i];
        rd_chk("filt_out", ad(3, r, KIND_RESULT), rv(1'b1, 0, y));
      end
    end
    bus_wr(ad(3, 3, KIND_CTRL), {26'h0, MODE_FILTER, 4'h0});
    core_u.send(3, 3, 12'h123);
    rd_chk("filt_other", ad(3, 3, KIND_RESULT), rv(1'b1, 0, 32'h123));
    $display("done filter");
  endtask
  task automatic t_diff();
    bus_wr(ad(4, 0, KIND_CTRL), {26'h0, MODE_DIFF, 4'h0});
    core_u.send(4, 0, 12'h300);
    rd_chk("diff_ref", ad(4, 0, KIND_RESULT), rv(1'b1, 0, 32'h300));
    bus_wr(ad(4, 9, KIND_CTRL), {26'h0, MODE_DIFF, 4'h0});
    core_u.send(4, 9, 12'h100);
    rd_chk("diff_wrap", ad(4, 9, KIND_RESULT), rv(1'b1, 0, 32'hFE00));
    $display("done difference");
  endtask
  task automatic t_misc();
    bus_wr(ad(5, 2, KIND_CTRL), 32'hFFFF_FF39, 1'b0);
    rd_chk("ctrl_back", ad(5, 2, KIND_CTRL), 32'h0000_0039);
    core_u.send(5, 2, 12'h077);
    rd_chk("mode3", ad(5, 2, KIND_RESULT), rv(1'b1, 0, 32'h077));
    core_u.send(5, 2, 12'h0AA);
    rd_chk("rd_clear", ad(5, 2, KIND_RESULT), rv(1'b0, 0, 32'h0AA), 2);
    bus_wr(ad(5, 2, KIND_CTRL), 32'h0000_0030, 1'b0);
    rd_chk("cfg_clear", ad(5, 2, KIND_RESULT), 32'h0);
    core_u.send(13, 2, 12'h055);
    rd_chk("bad_group", ad(5, 2, KIND_RESULT), 32'h0);
    bus_wr(ad(12, 0, KIND_CTRL), 32'h0000_0013, 1'b0);
    rd_chk("bad_wr", ad(12, 0, KIND_CTRL), 32'h0);
    rd_chk("bad_addr", 10'h200, 32'h0);
    $display("done misc");
  endtask
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 10'h000;
    wdata_i = 32'h0000_0000;
    fails = 0;
    checks = 0;
    cycles = 0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reduce();
    t_filter();
    t_diff();
    t_misc();
    finish_test();
  end
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end
endmodule // testbench
`default_nettype wire
